// ==== hdl/cis_cfg.svh ====
// Constants for the instruction slice executor: opcodes, cycle counts,
// mask bits and condition-code bit positions.
// Assumes inclusion by bare name from the core, the checker and the bench.
`ifndef CIS_CFG_SVH
`define CIS_CFG_SVH
`define CIS_OP_LOAD_CONCAT_LONG     16'h2771
`define CIS_OP_STORE_CONCAT_LONG     16'h2773
`define CIS_OP_LOW_POWER_HALT_INSN   16'h27F1
`define CIS_OP_MAC1     16'h007B
`define CIS_OP_MACR     16'h00FB
`define CIS_OP_PUSHSET  16'h0034
`define CIS_OP_PULLSET  16'h0035
`define CIS_OP_SAVEMAC  16'h27B8
`define CIS_OP_RESTMAC  16'h27B9
`define CIS_OP_PUSHA    16'h3708
`define CIS_OP_RETEXC   16'h2777
`define CIS_OP_RETSUB   16'h27F7
`define CIS_OP_MB_IX    16'h0030
`define CIS_OP_MB_XI    16'h0032
`define CIS_OP_MB_XX    16'h37FE
`define CIS_OP_MW_IX    16'h0031
`define CIS_OP_MW_XI    16'h0033
`define CIS_OP_MW_XX    16'h37FF
`define CIS_OP_ORFLAGS  16'h373B
`define CIS_OP_SUB_BORROW_ACCUM_A_X   16'h0042
`define CIS_CYC_LOAD_CONCAT_LONG    6'd8
`define CIS_CYC_STORE_CONCAT_LONG    6'd8
`define CIS_CYC_NOP     6'd4
`define CIS_CYC_STOP    6'd20
`define CIS_CYC_MAC     6'd12
`define CIS_CYC_RMACB   6'd6
`define CIS_CYC_PSHB    6'd4
`define CIS_CYC_PULB    6'd4
`define CIS_CYC_SAVEMAC 6'd14
`define CIS_CYC_RESTMAC 6'd16
`define CIS_CYC_PUSHA   6'd4
`define CIS_CYC_RET     6'd12
`define CIS_CYC_MOV     6'd8
`define CIS_CYC_MOVXX   6'd10
`define CIS_CYC_ORP     6'd4
`define CIS_CYC_SUB_BORROW_ACCUM_A    6'd6
`define CIS_CYC_ILL     6'd2
`define CIS_RTI_PC_ADJ  16'h0006
`define CIS_RTS_PC_ADJ  16'h0002
`define CIS_MASK_RSVD   3'd7
`define CIS_CC_S        15
`define CIS_CC_N        11
`define CIS_CC_Z        10
`define CIS_CC_V        9
`define CIS_CC_C        8
`define CIS_PK_LSB      0
`define CIS_PK_MASK     16'h000F
`define CIS_CCR_UP_MASK 16'hFFF0
`define CIS_MAC_WORDS   3'd6
`endif

// ==== hdl/cis_pkg.sv ====
// Types for the instruction slice executor.
// Assumes cis_cfg.svh is on the include path.
package cis_pkg;
  typedef enum logic [2:0] {
    CIS_IDLE = 3'b000,
    CIS_EXEC = 3'b001,
    CIS_MEM  = 3'b010,
    CIS_WAIT = 3'b011,
    CIS_STOP = 3'b100
  } cis_state_type;
endpackage : cis_pkg

// ==== hdl/cis_core.sv ====
// Executor for the load-to-store instruction slice of a 16-bit CPU.
// Assumes a single-cycle word memory port on the same clock and an
// opcode/operand presented with i_start by the fetch unit.
`include "cis_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module cis_core (
  input  wire logic        i_core_clk,   // 20 MHz clock
  input  wire logic        i_rst_b,      // Sync reset, low
  input  wire logic        i_start,      // Opcode valid
  input  wire logic [15:0] i_opcode,     // Opcode
  input  wire logic [15:0] i_oper0,      // First operand word
  input  wire logic [15:0] i_oper1,      // Second operand word
  input  wire logic [15:0] i_mem_rdata,  // Memory read data
  output logic             o_mem_req,    // Memory access
  output logic             o_mem_we,     // Write enable
  output logic      [15:0] o_mem_addr,   // Word address
  output logic      [15:0] o_mem_wdata,  // Write data
  output logic             o_busy,       // Instruction running
  output logic             o_done,       // Completion pulse
  output logic             o_illegal,    // Illegal opcode pulse
  output logic             o_stopped,    // Stop state
  output logic      [15:0] o_acc_d,      // Accumulator D
  output logic      [15:0] o_acc_e,      // Accumulator E
  output logic      [15:0] o_sp,         // Stack pointer
  output logic      [15:0] o_pc,         // Program counter
  output logic      [15:0] o_ccr,        // Flags register
  output logic      [35:0] o_mac_acc     // Wide accumulator
);
  import cis_pkg::*;

  typedef struct packed {
    cis_state_type st;
    logic [15:0] op;
    logic [15:0] o0;
    logic [15:0] o1;
    logic [5:0]  cyc;
    logic [2:0]  step;
    logic [15:0] d, e, ix, iy, iz, k, sp, pc, condition_flags_reg, hr, ir;
    logic [35:0] am;
    logic        req, we, busy, done, ill, stopped;
    logic [15:0] addr, wdata;
  } cis_regs_type;

  cis_regs_type r_q, r_d;

  ////////////////////////////////////////////////////////////////////////
  // Register selectors for the set push and the MAC save, and the opcode decode
  function automatic logic [15:0] cis_sel(input cis_regs_type r,
                                          input logic [2:0] idx);
    case (idx)
      3'd0: cis_sel = r.d;
      3'd1: cis_sel = r.e;
      3'd2: cis_sel = r.ix;
      3'd3: cis_sel = r.iy;
      3'd4: cis_sel = r.iz;
      3'd5: cis_sel = r.k;
      default: cis_sel = r.condition_flags_reg;
    endcase
  endfunction : cis_sel

  function automatic logic [15:0] cis_mac_word(input cis_regs_type r,
                                               input logic [2:0] idx);
    case (idx)
      3'd0: cis_mac_word = r.hr;
      3'd1: cis_mac_word = r.ir;
      3'd2: cis_mac_word = r.am[15:0];
      3'd3: cis_mac_word = r.am[31:16];
      3'd4: cis_mac_word = {12'h000, r.am[35:32]};
      default: cis_mac_word = r.k;
    endcase
  endfunction : cis_mac_word

  function automatic logic cis_known(input logic [15:0] op);
    case (op)
      `CIS_OP_LOAD_CONCAT_LONG, `CIS_OP_STORE_CONCAT_LONG, `CIS_OP_LOW_POWER_HALT_INSN, `CIS_OP_MAC1,
      `CIS_OP_MACR, `CIS_OP_PUSHSET, `CIS_OP_PULLSET, `CIS_OP_SAVEMAC,
      `CIS_OP_RESTMAC, `CIS_OP_PUSHA, `CIS_OP_RETEXC, `CIS_OP_RETSUB,
      `CIS_OP_MB_IX, `CIS_OP_MB_XI, `CIS_OP_MB_XX, `CIS_OP_MW_IX,
      `CIS_OP_MW_XI, `CIS_OP_MW_XX, `CIS_OP_ORFLAGS,
      `CIS_OP_SUB_BORROW_ACCUM_A_X: cis_known = 1'b1;
      default: cis_known = 1'b0;
    endcase
  endfunction : cis_known

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic
  logic [31:0] prod;
  logic [8:0]  sbc;
  logic [15:0] xstep, ystep;
  logic [2:0]  idx;

  always_comb begin
    r_d   = r_q;
    prod  = 32'($signed(r_q.hr) * $signed(r_q.ir));
    xstep = {{12{r_q.o0[7]}}, r_q.o0[7:4]};
    ystep = {{12{r_q.o0[3]}}, r_q.o0[3:0]};
    sbc   = {1'b0, r_q.d[15:8]} - {1'b0, r_q.o1[7:0]}
            - {8'h00, r_q.condition_flags_reg[`CIS_CC_C]};
    idx   = (r_q.op == `CIS_OP_PULLSET) ? 3'(6 - r_q.step) : r_q.step;
    r_d.req  = 1'b0;
    r_d.we   = 1'b0;
    r_d.done = 1'b0;
    r_d.ill  = 1'b0;
    case (r_q.st)
      CIS_IDLE: begin
        if (i_start) begin
          r_d.op = i_opcode;
          r_d.o0 = i_oper0;
          r_d.o1 = i_oper1;
          r_d.step = 3'd0;
          r_d.busy = 1'b1;
          if (!cis_known(i_opcode) || (((i_opcode == `CIS_OP_PUSHSET) ||
              (i_opcode == `CIS_OP_PULLSET)) &&
              i_oper0[`CIS_MASK_RSVD])) begin
            r_d.ill = 1'b1;
            r_d.cyc = `CIS_CYC_ILL;
            r_d.st  = CIS_WAIT;
          end else begin
            r_d.st = CIS_EXEC;
          end
        end
      end
      CIS_EXEC: begin
        r_d.st = CIS_WAIT;
        case (r_q.op)
          `CIS_OP_LOAD_CONCAT_LONG: begin
            r_d.addr = r_q.o0; r_d.req = 1'b1; r_d.st = CIS_MEM;
            r_d.cyc = `CIS_CYC_LOAD_CONCAT_LONG;
          end
          `CIS_OP_STORE_CONCAT_LONG: begin
            r_d.addr = r_q.o0; r_d.wdata = r_q.e;
            r_d.req = 1'b1; r_d.we = 1'b1; r_d.st = CIS_MEM;
            r_d.cyc = `CIS_CYC_STORE_CONCAT_LONG;
          end
          `CIS_OP_LOW_POWER_HALT_INSN: begin
            if (r_q.condition_flags_reg[`CIS_CC_S]) begin
              r_d.cyc = `CIS_CYC_STOP; r_d.st = CIS_STOP;
            end else begin
              r_d.cyc = `CIS_CYC_NOP;
            end
          end
          `CIS_OP_MAC1, `CIS_OP_MACR: begin
            if (r_q.op == `CIS_OP_MACR && r_q.e[15]) begin
              r_d.cyc = `CIS_CYC_RMACB;
            end else begin
              r_d.am = r_q.am + {{4{prod[31]}}, prod};
              r_d.ix = r_q.ix + xstep;
              r_d.iy = r_q.iy + ystep;
              r_d.addr = r_q.ix + xstep;
              r_d.req = 1'b1;
              r_d.st = CIS_MEM;
              r_d.cyc = `CIS_CYC_MAC;
              if (r_q.op == `CIS_OP_MACR)
                r_d.e = r_q.e - 16'h0001;
            end
          end
          `CIS_OP_PUSHSET, `CIS_OP_PULLSET: begin
            r_d.cyc = (r_q.op == `CIS_OP_PUSHSET) ? `CIS_CYC_PSHB
                                                   : `CIS_CYC_PULB;
            r_d.st = CIS_MEM;
          end
          `CIS_OP_SAVEMAC: begin
            r_d.cyc = `CIS_CYC_SAVEMAC; r_d.st = CIS_MEM;
          end
          `CIS_OP_RESTMAC: begin
            r_d.cyc = `CIS_CYC_RESTMAC; r_d.st = CIS_MEM;
          end
          `CIS_OP_PUSHA: begin
            r_d.addr = r_q.sp + 16'h0001;
            r_d.wdata = {8'h00, r_q.d[15:8]};
            r_d.req = 1'b1; r_d.we = 1'b1;
            r_d.sp = r_q.sp - 16'h0001;
            r_d.cyc = `CIS_CYC_PUSHA;
          end
          `CIS_OP_RETEXC, `CIS_OP_RETSUB: begin
            r_d.sp = r_q.sp + 16'h0002;
            r_d.addr = r_q.sp + 16'h0002;
            r_d.req = 1'b1; r_d.st = CIS_MEM;
            r_d.cyc = `CIS_CYC_RET;
          end
          `CIS_OP_MB_IX, `CIS_OP_MB_XI, `CIS_OP_MB_XX,
          `CIS_OP_MW_IX, `CIS_OP_MW_XI, `CIS_OP_MW_XX: begin
            r_d.addr = (r_q.op == `CIS_OP_MB_IX || r_q.op == `CIS_OP_MW_IX)
                       ? r_q.ix + {{8{r_q.o0[7]}}, r_q.o0[7:0]} : r_q.o0;
            r_d.req = 1'b1; r_d.st = CIS_MEM;
            r_d.cyc = (r_q.op == `CIS_OP_MB_XX || r_q.op == `CIS_OP_MW_XX)
                      ? `CIS_CYC_MOVXX : `CIS_CYC_MOV;
          end
          `CIS_OP_ORFLAGS: begin
            r_d.condition_flags_reg = r_q.condition_flags_reg | (r_q.o0 & `CIS_CCR_UP_MASK);
            r_d.cyc = `CIS_CYC_ORP;
          end
          default: begin
            r_d.d[15:8] = sbc[7:0];
            r_d.condition_flags_reg[`CIS_CC_N] = sbc[7];
            r_d.condition_flags_reg[`CIS_CC_Z] = (sbc[7:0] == 8'h00);
            r_d.condition_flags_reg[`CIS_CC_V] = (r_q.d[15] ^ r_q.o1[7]) &
                                 (r_q.d[15] ^ sbc[7]);
            r_d.condition_flags_reg[`CIS_CC_C] = sbc[8];
            r_d.cyc = `CIS_CYC_SUB_BORROW_ACCUM_A;
          end
        endcase
      end
      CIS_MEM: begin
        r_d.step = r_q.step + 3'd1;
        r_d.cyc  = r_q.cyc - 6'd1;
        case (r_q.op)
          `CIS_OP_LOAD_CONCAT_LONG: begin
            if (r_q.step == 3'd0) begin
              r_d.e = i_mem_rdata; r_d.addr = r_q.addr + 16'h0002;
              r_d.req = 1'b1;
            end else begin
              r_d.d = i_mem_rdata; r_d.st = CIS_WAIT;
            end
          end
          `CIS_OP_STORE_CONCAT_LONG: begin
            r_d.addr = r_q.addr + 16'h0002; r_d.wdata = r_q.d;
            r_d.req = 1'b1; r_d.we = 1'b1; r_d.st = CIS_WAIT;
          end
          `CIS_OP_MAC1, `CIS_OP_MACR: begin
            if (r_q.step == 3'd0) begin
              r_d.hr = i_mem_rdata; r_d.addr = r_q.iy; r_d.req = 1'b1;
            end else begin
              r_d.ir = i_mem_rdata;
              r_d.step = 3'd0;
              r_d.st = (r_q.op == `CIS_OP_MACR) ? CIS_EXEC : CIS_WAIT;
            end
          end
          `CIS_OP_PUSHSET: begin
            if (r_q.o0[r_q.step[2:0]]) begin
              r_d.addr = r_q.sp; r_d.wdata = cis_sel(r_q, r_q.step);
              r_d.req = 1'b1; r_d.we = 1'b1;
              r_d.sp = r_q.sp - 16'h0002;
              r_d.cyc = r_q.cyc + 6'd1;
            end
            if (r_q.step == 3'd6) r_d.st = CIS_WAIT;
          end
          `CIS_OP_PULLSET: begin
            if (r_q.step != 3'd0 && r_q.o0[3'(r_q.step - 3'd1)]) begin
              if (idx == 3'd5) r_d.condition_flags_reg = (i_mem_rdata & `CIS_CCR_UP_MASK)
                                 | (r_q.condition_flags_reg & `CIS_PK_MASK);
              else if (idx == 3'd4) r_d.k = i_mem_rdata;
              else if (idx == 3'd3) r_d.iz = i_mem_rdata;
              else if (idx == 3'd2) r_d.iy = i_mem_rdata;
              else if (idx == 3'd1) r_d.ix = i_mem_rdata;
              else if (idx == 3'd0) r_d.e = i_mem_rdata;
              else r_d.d = i_mem_rdata;
            end
            if (r_q.step == 3'd7) r_d.st = CIS_WAIT;
            else if (r_q.o0[r_q.step]) begin
              r_d.sp = r_q.sp + 16'h0002; r_d.addr = r_q.sp + 16'h0002;
              r_d.req = 1'b1; r_d.cyc = r_q.cyc + 6'd1;
            end
          end
          `CIS_OP_SAVEMAC: begin
            r_d.addr = r_q.sp; r_d.wdata = cis_mac_word(r_q, r_q.step);
            r_d.req = 1'b1; r_d.we = 1'b1; r_d.sp = r_q.sp - 16'h0002;
            if (r_q.step == `CIS_MAC_WORDS - 3'd1) r_d.st = CIS_WAIT;
          end
          `CIS_OP_RESTMAC: begin
            if (r_q.step != 3'd0) begin
              case (r_q.step)
                3'd1: r_d.k = i_mem_rdata;
                3'd2: r_d.am[35:32] = i_mem_rdata[3:0];
                3'd3: r_d.am[31:16] = i_mem_rdata;
                3'd4: r_d.am[15:0] = i_mem_rdata;
                3'd5: r_d.ir = i_mem_rdata;
                default: r_d.hr = i_mem_rdata;
              endcase
            end
            if (r_q.step == `CIS_MAC_WORDS) r_d.st = CIS_WAIT;
            else begin
              r_d.sp = r_q.sp + 16'h0002; r_d.addr = r_q.sp + 16'h0002;
              r_d.req = 1'b1;
            end
          end
          `CIS_OP_RETEXC, `CIS_OP_RETSUB: begin
            if (r_q.step == 3'd0) begin
              if (r_q.op == `CIS_OP_RETEXC) r_d.condition_flags_reg = i_mem_rdata;
              else r_d.condition_flags_reg = (r_q.condition_flags_reg & ~`CIS_PK_MASK)
                             | (i_mem_rdata & `CIS_PK_MASK);
              r_d.sp = r_q.sp + 16'h0002; r_d.addr = r_q.sp + 16'h0002;
              r_d.req = 1'b1;
            end else begin
              r_d.pc = i_mem_rdata - ((r_q.op == `CIS_OP_RETEXC) ?
                       `CIS_RTI_PC_ADJ : `CIS_RTS_PC_ADJ);
              r_d.st = CIS_WAIT;
            end
          end
          default: begin
            if (r_q.step == 3'd0) begin
              r_d.wdata = (r_q.op == `CIS_OP_MB_IX || r_q.op == `CIS_OP_MB_XI
                || r_q.op == `CIS_OP_MB_XX) ? {8'h00, i_mem_rdata[7:0]}
                : i_mem_rdata;
              r_d.addr = (r_q.op == `CIS_OP_MB_XI || r_q.op == `CIS_OP_MW_XI)
                ? r_q.ix + {{8{r_q.o1[7]}}, r_q.o1[7:0]} : r_q.o1;
              r_d.req = 1'b1; r_d.we = 1'b1;
              if (r_q.op == `CIS_OP_MB_IX || r_q.op == `CIS_OP_MB_XI ||
                  r_q.op == `CIS_OP_MB_XX) begin
                r_d.condition_flags_reg[`CIS_CC_N] = i_mem_rdata[7];
                r_d.condition_flags_reg[`CIS_CC_Z] = (i_mem_rdata[7:0] == 8'h00);
                r_d.condition_flags_reg[`CIS_CC_V] = 1'b0;
              end
              r_d.st = CIS_WAIT;
            end
          end
        endcase
      end
      CIS_WAIT, CIS_STOP: begin
        if (r_q.cyc <= 6'd3) begin
          r_d.st = (r_q.st == CIS_STOP) ? CIS_STOP : CIS_IDLE;
          r_d.stopped = (r_q.st == CIS_STOP);
          r_d.busy = (r_q.st == CIS_STOP);
          r_d.done = (r_q.st != CIS_STOP) || !r_q.stopped;
          r_d.cyc = 6'd3;
        end else begin
          r_d.cyc = r_q.cyc - 6'd1;
        end
      end
      default: r_d.st = CIS_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      r_q     <= '0;
      r_q.st  <= CIS_IDLE;
    end else begin
      r_q <= r_d;
    end
  end

  assign o_mem_req   = r_q.req;
  assign o_mem_we    = r_q.we;
  assign o_mem_addr  = r_q.addr;
  assign o_mem_wdata = r_q.wdata;
  assign o_busy      = r_q.busy;
  assign o_done      = r_q.done;
  assign o_illegal   = r_q.ill;
  assign o_stopped   = r_q.stopped;
  assign o_acc_d     = r_q.d;
  assign o_acc_e     = r_q.e;
  assign o_sp        = r_q.sp;
  assign o_pc        = r_q.pc;
  assign o_ccr       = r_q.condition_flags_reg;
  assign o_mac_acc   = r_q.am;
endmodule : cis_core
`default_nettype wire

// ==== verification/cis_core_assertions.sv ====
// Port-level checks on the slice executor.
// Assumes one clock and the synchronous active-low reset.
`include "cis_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module cis_core_assertions (
  input wire logic        i_core_clk,  // Clock
  input wire logic        i_rst_b,     // Reset
  input wire logic        i_start,     // Start
  input wire logic [15:0] i_opcode,    // Opcode
  input wire logic [15:0] i_oper0,     // Operand
  input wire logic [15:0] i_oper1,     // Operand
  input wire logic [15:0] i_mem_rdata, // Rdata
  input wire logic        o_mem_req,   // Access
  input wire logic        o_mem_we,    // Write
  input wire logic [15:0] o_mem_addr,  // Address
  input wire logic [15:0] o_mem_wdata, // Wdata
  input wire logic        o_busy,      // Busy
  input wire logic        o_done,      // Done
  input wire logic        o_illegal,   // Illegal
  input wire logic        o_stopped,   // Stopped
  input wire logic [15:0] o_acc_d,     // D
  input wire logic [15:0] o_acc_e,     // E
  input wire logic [15:0] o_sp,        // SP
  input wire logic [15:0] o_pc,        // PC
  input wire logic [15:0] o_ccr,       // Flags
  input wire logic [35:0] o_mac_acc    // Wide acc
);
  logic        take;
  logic [15:0] a_q, ccr_q, sp_q, d_q, e_q;
  assign take = i_start && !o_busy;
  // State seen when an instruction is taken
  always_ff @(posedge i_core_clk) begin
    if (take) begin
      a_q   <= i_oper0;
      ccr_q <= o_ccr;
      sp_q  <= o_sp;
      d_q   <= o_acc_d;
      e_q   <= o_acc_e;
    end
  end
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_b);
  ////////////////////////////////////////////////////////////////////
  sequence rd_at(logic [15:0] ad);
    o_mem_req && !o_mem_we && o_mem_addr == ad;
  endsequence
  sequence wr_at(logic [15:0] ad, logic [15:0] dt);
    o_mem_req && o_mem_we && o_mem_addr == ad && o_mem_wdata == dt;
  endsequence
  property ends_with(logic [15:0] op, logic ok);
    take && i_opcode == op |=> ##[0:30] o_done ##1 ok;
  endproperty
  long_load_a: assert property (
    take && i_opcode == `CIS_OP_LOAD_CONCAT_LONG |=>
      ##[0:8] rd_at(a_q) ##[1:4] rd_at(a_q + 16'h0002))
    else $error("long load reads wrong words");
  long_store_a: assert property (
    take && i_opcode == `CIS_OP_STORE_CONCAT_LONG |=>
      ##[0:8] wr_at(a_q, e_q) ##[1:4] wr_at(a_q + 16'h0002, d_q))
    else $error("long store writes wrong words");
  stop_gate_a: assert property (
    $rose(o_stopped) |-> o_ccr[`CIS_CC_S])
    else $error("stop entered while disabled");
  stop_hold_a: assert property (
    o_stopped |=> o_stopped && o_busy && !o_done)
    else $error("stop state left");
  orp_merge_a: assert property (ends_with(`CIS_OP_ORFLAGS,
    o_ccr == ((ccr_q | (a_q & `CIS_CCR_UP_MASK)))))
    else $error("or into flags wrong");
  push_a_sp_a: assert property (ends_with(`CIS_OP_PUSHA,
    o_sp == sp_q - 16'h0001))
    else $error("push a stack pointer wrong");
  save_mac_a: assert property (ends_with(`CIS_OP_SAVEMAC,
    o_ccr == ccr_q && o_sp == sp_q - 16'h000c))
    else $error("mac save changed flags or sp");
  return_sp_a: assert property (ends_with(`CIS_OP_RETSUB,
    o_sp == sp_q + 16'h0004 &&
    (o_ccr & `CIS_CCR_UP_MASK) == (ccr_q & `CIS_CCR_UP_MASK)))
    else $error("subroutine return wrong");
  illegal_keep_a: assert property (
    o_illegal |-> ##[0:4] o_done ##1
      (o_sp == sp_q && o_acc_d == d_q && o_acc_e == e_q))
    else $error("illegal opcode changed state");
endmodule : cis_core_assertions
bind cis_core cis_core_assertions u_chk (
  .i_core_clk, .i_rst_b, .i_start, .i_opcode, .i_oper0, .i_oper1,
  .i_mem_rdata, .o_mem_req, .o_mem_we, .o_mem_addr, .o_mem_wdata,
  .o_busy, .o_done, .o_illegal, .o_stopped, .o_acc_d, .o_acc_e,
  .o_sp, .o_pc, .o_ccr, .o_mac_acc
);
`default_nettype wire

// ==== verification/cis_mem_model.sv ====
// Word memory standing in for the processor bus.
// Assumes reads are taken in the cycle the request stands.
`timescale 1ns/1ps
`default_nettype none
module cis_mem_model (
  input  wire logic        i_core_clk,  // Clock
  input  wire logic        i_mem_req,   // Access
  input  wire logic        i_mem_we,    // Write
  input  wire logic [15:0] i_mem_addr,  // Address
  input  wire logic [15:0] i_mem_wdata, // Wdata
  output logic      [15:0] o_mem_rdata  // Rdata
);
  logic [15:0] mem [int];
  logic [15:0] stale_q = 16'h0000;
  always @(posedge i_core_clk) begin
    if (i_mem_req && i_mem_we) begin
      mem[int'(i_mem_addr)] = i_mem_wdata;
    end
    // Stale data toggles outside the read slot
    stale_q <= ~stale_q;
  end
  // Read data answers in the cycle the request stands
  always @(i_mem_req, i_mem_we, i_mem_addr, stale_q) begin
    if (i_mem_req && !i_mem_we) begin
      // Unwritten words read as an address pattern
      o_mem_rdata = mem.exists(int'(i_mem_addr)) ?
                    mem[int'(i_mem_addr)] : i_mem_addr ^ 16'ha5c3;
    end else begin
      o_mem_rdata = stale_q;
    end
  end
endmodule : cis_mem_model
`default_nettype wire

// ==== verification/tb_top.sv ====
// Self-checking bench for the slice executor.
// Assumes the core, memory model and checker are compiled first.
`include "cis_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        i_core_clk, i_rst_b, i_start, ill;
  logic [15:0] i_opcode, i_oper0, i_oper1, i_mem_rdata;
  logic        o_mem_req, o_mem_we, o_busy, o_done, o_illegal, o_stopped;
  logic [15:0] o_mem_addr, o_mem_wdata, o_acc_d, o_acc_e, o_sp, o_pc;
  logic [15:0] o_ccr, waddr, wdata, md, me, msp, mccr, a, b, m;
  logic [35:0] o_mac_acc;
  logic [15:0] xm [int];
  logic [15:0] pm [3] = '{16'h0001, 16'h0050, 16'h007f};
  logic [15:0] il [3] = '{`CIS_OP_PUSHSET, `CIS_OP_PULLSET, 16'hffff};
  logic [15:0] mv [6] = '{`CIS_OP_MB_IX, `CIS_OP_MB_XI, `CIS_OP_MB_XX,
                          `CIS_OP_MW_IX, `CIS_OP_MW_XI, `CIS_OP_MW_XX};
  int          failures, checked, nwr, n, k;
  cis_core dut (.i_core_clk, .i_rst_b, .i_start, .i_opcode, .i_oper0,
    .i_oper1, .i_mem_rdata, .o_mem_req, .o_mem_we, .o_mem_addr,
    .o_mem_wdata, .o_busy, .o_done, .o_illegal, .o_stopped, .o_acc_d,
    .o_acc_e, .o_sp, .o_pc, .o_ccr, .o_mac_acc);
  cis_mem_model mem (.i_core_clk, .i_mem_req(o_mem_req),
    .i_mem_we(o_mem_we), .i_mem_addr(o_mem_addr),
    .i_mem_wdata(o_mem_wdata), .o_mem_rdata(i_mem_rdata));
  ////////////////////////////////////////////////////////////////////
  task automatic conclude();
    if (failures == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : conclude
  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                     input string what);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk
  function automatic logic [15:0] mx(input logic [15:0] ad);
    return xm.exists(int'(ad)) ? xm[int'(ad)] : ad ^ 16'ha5c3;
  endfunction : mx
  // One instruction, entered just after an edge
  task automatic run(input logic [15:0] op, input logic [15:0] x,
                     input logic [15:0] y);
    nwr = 0;
    ill = 1'b0;
    i_opcode = op;
    i_oper0 = x;
    i_oper1 = y;
    i_start = 1'b1;
    n = 0;
    do begin
      @(posedge i_core_clk);
      #1;
      i_start = 1'b0;
      if (o_mem_req === 1'b1 && o_mem_we === 1'b1) begin
        nwr++;
        waddr = o_mem_addr;
        wdata = o_mem_wdata;
      end
      ill = ill | (o_illegal === 1'b1);
      n++;
    end while (o_done !== 1'b1 && n < 600);
    chk(16'(n < 600), 16'h0001, "done timeout");
    if (n >= 600) conclude();
    @(posedge i_core_clk);
    #1;
  endtask : run
  ////////////////////////////////////////////////////////////////////
  initial begin
    i_core_clk = 1'b0;
    forever #25 i_core_clk = ~i_core_clk;
  end
  initial begin
    failures = 0;
    checked = 0;
    i_rst_b = 1'b0;
    i_start = 1'b0;
    i_opcode = 16'h0000;
    i_oper0 = 16'h0000;
    i_oper1 = 16'h0000;
    void'($urandom(32'hb9e2_176e));
    repeat (5) @(posedge i_core_clk);
    #1;
    i_rst_b = 1'b1;
    chk(o_sp | o_pc | o_ccr | o_acc_d | o_acc_e, 16'h0000, "reset");
    a = 16'h1000 | (16'($urandom) & 16'h0ffe);
    run(`CIS_OP_LOAD_CONCAT_LONG, a, 16'h0000);
    me = mx(a);
    md = mx(a + 16'h0002);
    chk(o_acc_e, me, "load e");
    chk(o_acc_d, md, "load d");
    b = 16'h3000 | (16'($urandom) & 16'h0ffe);
    run(`CIS_OP_STORE_CONCAT_LONG, b, 16'h0000);
    xm[int'(b)] = me;
    xm[int'(b + 16'h0002)] = md;
    chk(16'(nwr), 16'h0002, "store count");
    run(`CIS_OP_LOAD_CONCAT_LONG, b + 16'h0002, 16'h0000);
    md = mx(b + 16'h0004);
    chk(o_acc_e, mx(b + 16'h0002), "store readback");
    m = 16'($urandom) & 16'h00ff;
    b = {8'h00, md[15:8]};
    run(`CIS_OP_SUB_BORROW_ACCUM_A_X, 16'h0000, m);
    k = int'(b) - int'(m);
    md[15:8] = k[7:0];
    chk(o_acc_d, md, "sbc result");
    chk(16'({o_ccr[`CIS_CC_N], o_ccr[`CIS_CC_Z], o_ccr[`CIS_CC_V],
        o_ccr[`CIS_CC_C]}), 16'({k[7], k[7:0] == 8'h00,
        (b[7] ^ m[7]) & (b[7] ^ k[7]), k < 0}), "sbc flags");
    run(`CIS_OP_LOW_POWER_HALT_INSN, 16'h0000, 16'h0000);
    chk(16'(o_stopped), 16'h0000, "halt disabled");
    run(`CIS_OP_RETEXC, 16'h0000, 16'h0000);
    mccr = mx(16'h0002);
    chk(o_ccr, mccr, "rti flags");
    chk(o_pc, mx(16'h0004) - 16'h0006, "rti pc");
    chk(o_sp, 16'h0004, "rti sp");
    run(`CIS_OP_RETSUB, 16'h0000, 16'h0000);
    chk(o_pc, mx(16'h0008) - 16'h0002, "rts pc");
    msp = 16'h0008;
    m = 16'($urandom);
    run(`CIS_OP_ORFLAGS, m, 16'h0000);
    mccr = (mccr | m) & `CIS_CCR_UP_MASK;
    chk(o_ccr & `CIS_CCR_UP_MASK, mccr, "or flags");
    run(`CIS_OP_PUSHA, 16'h0000, 16'h0000);
    msp = msp - 16'h0001;
    chk(o_sp, msp, "push a sp");
    chk(16'(nwr), 16'h0001, "push a writes");
    for (int i = 0; i < 3; i++) begin
      md = o_acc_d;
      me = o_acc_e;
      run(`CIS_OP_PUSHSET, pm[i], 16'h0000);
      msp = msp - 16'(2 * $countones(pm[i]));
      chk(o_sp, msp, "push set sp");
      chk(16'(nwr), 16'($countones(pm[i])), "push set writes");
      run(`CIS_OP_PULLSET, pm[i], 16'h0000);
      msp = msp + 16'(2 * $countones(pm[i]));
      chk(o_sp, msp, "pull set sp");
      if (i == 2) begin
        chk(o_acc_d, md, "pull set d");
        chk(o_acc_e, me, "pull set e");
      end
      run(il[i], 16'h0081, 16'h0000);
      chk(16'(ill), 16'h0001, "illegal flag");
      chk(o_sp, msp, "illegal sp");
    end
    run(`CIS_OP_SAVEMAC, 16'h0000, 16'h0000);
    chk(o_sp, msp - 16'h000c, "mac save sp");
    chk(16'(nwr), 16'h0006, "mac save writes");
    run(`CIS_OP_RESTMAC, 16'h0000, 16'h0000);
    chk(o_sp, msp, "mac restore sp");
    for (int i = 0; i < 6; i++) begin
      a = 16'h5000 | (16'($urandom) & 16'h0ffe);
      b = 16'h7000 | (16'($urandom) & 16'h0ffe);
      run(mv[i], a, b);
      chk(16'({ill, nwr == 1}), 16'h0001, "copy writes");
      m = mx(a);
      if (i == 2) begin
        chk(16'({o_ccr[`CIS_CC_N], o_ccr[`CIS_CC_Z]}),
            16'({m[7], m[7:0] == 8'h00}), "copy flags");
      end
    end
    chk(waddr, b, "word copy dest");
    chk(wdata, mx(a), "word copy data");
    chk(16'(o_ccr[`CIS_CC_V]), 16'h0000, "copy overflow");
    run(`CIS_OP_LOAD_CONCAT_LONG, 16'ha5c1, 16'h0000);
    run(`CIS_OP_MAC1, 16'h0000, 16'h0000);
    chk(16'(ill), 16'h0000, "mac decoded");
    chk(o_mac_acc[15:0], 16'h0000, "mac acc");
    run(`CIS_OP_LOAD_CONCAT_LONG, 16'ha5c1, 16'h0000);
    run(`CIS_OP_MACR, 16'h0000, 16'h0000);
    chk(o_acc_e, 16'hffff, "repeat mac end");
    i_rst_b = 1'b0;
    repeat (2) @(posedge i_core_clk);
    #1;
    i_rst_b = 1'b1;
    chk(o_sp | o_pc | o_ccr | o_acc_d | o_acc_e, 16'h0000, "reset again");
    run(`CIS_OP_ORFLAGS, 16'h8000, 16'h0000);
    i_opcode = `CIS_OP_LOW_POWER_HALT_INSN;
    i_start = 1'b1;
    for (n = 0; n < 40 && o_stopped !== 1'b1; n++) begin
      @(posedge i_core_clk);
      #1;
      i_start = 1'b0;
    end
    repeat (4) @(posedge i_core_clk);
    #1;
    chk(16'({o_stopped, o_busy}), 16'h0003, "halt entered");
    conclude();
  end
endmodule : tb_top
`default_nettype wire
